// ### core/sms_slave_link.sv
// Slave shifter clocked by the sample edge of SCK.
// Assumes arst is held while the slave is deselected or off, and that
// tx and order stay still while a byte is on the wire.
`timescale 1ns/100ps
module sms_slave_link (
    input  wire logic       sclk,
    input  wire logic       arst,
    input  wire logic       mosi,
    input  wire logic [7:0] tx,
    input  wire logic       order_lsb,
    output logic            miso,
    output logic            tgl,
    output logic [7:0]      hold,
    output logic            mid
);

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] rx;
        logic [7:0] hold;
        logic       tgl;
        logic       mid;
    } sms_link_s;

    sms_link_s s_q;
    sms_link_s s_d;
    logic [7:0] nrx;

    // Sample one bit per SCK cycle, eight to a byte
    always_comb
    begin
        s_d = s_q;
        nrx = order_lsb ? {mosi, s_q.rx[7:1]} : {s_q.rx[6:0], mosi};
        s_d.rx  = nrx;
        s_d.cnt = s_q.cnt + 3'h1;
        s_d.mid = (s_q.cnt != sms_pkg::BIT_LAST);
        if (s_q.cnt == sms_pkg::BIT_LAST)
        begin
            s_d.hold = nrx;
            s_d.tgl  = ~s_q.tgl;
        end
    end

    // Deselect clears the bit count and drops a partial byte
    always_ff @(posedge sclk or posedge arst)
    begin
        if (arst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Output bit moves on past the sample edge
    assign miso = order_lsb ? tx[s_q.cnt]
                            : tx[sms_pkg::BIT_LAST - s_q.cnt];
    assign tgl  = s_q.tgl;
    assign hold = s_q.hold;
    assign mid  = s_q.mid;

endmodule

// ### core/sms_spi_unit.sv
// Byte serial shift unit: master clock generator, slave link, flags.
// Assumes software strobes are one-cycle pulses on mclk and the SCK pin
// is wired to sck_link as well as driven from pins.sck_o.
//
// Contract
// - Power gate bit low enables the unit
// - MOSI master to slave, MISO back
// - Master data write starts eight-bit shift
// - Full byte stops clock, sets done flag
// - Done flag with enable raises interrupt
// - Last received byte held in buffer
// - Deselected slave idles, MISO tri-stated
// - Slave shifts preloaded data only when selected
// - Slave accepts new data before read
// - Transmit single, receive double buffered
// - Enabled unit overrides pin directions
// - Bit order selects LSB or MSB first
// - Double rate master SCK at half clock
// - Runs in idle, done wakes processor
// - Write during transfer sets collision flag
// - Done flag clears by vector or read pair, collision flag by read pair only
// - Master with SS input low drops
// - Polarity and phase give four modes
`timescale 1ns/100ps
module sms_spi_unit (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  sck_link,
    input  wire logic                  serial_power_gate_bit,
    input  wire sms_pkg::sms_ctrl_s    ctrl_in,
    input  wire sms_pkg::sms_sw_req_s  sw,
    input  wire sms_pkg::sms_dir_s     dir,
    input  wire sms_pkg::sms_pin_in_s  pins_in,
    output sms_pkg::sms_ctrl_s         serial_control_reg,
    output sms_pkg::sms_status_s       serial_status_reg,
    output logic [7:0]                 serial_data_reg,
    output logic                       irq_req,
    output sms_pkg::sms_pin_out_s      pins_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        sms_pkg::sms_ctrl_s   ctrl;
        logic [7:0]           tx;
        logic [7:0]           rx_buf;
        logic [7:0]           shift;
        logic                 done;
        logic                 coll;
        logic                 armed;
        sms_pkg::sms_mstate_e mst;
        logic [6:0]           div;
        logic [3:0]           edges;
        logic                 sck;
        logic                 mosi;
        logic                 seen;
    } sms_unit_s;

    sms_unit_s s_q;
    sms_unit_s s_d;

    logic       en;
    logic       master_mode;
    logic       slave_mode;
    logic       busy;
    logic       fault;
    logic       done_evt;
    logic       clr;
    logic       tick;
    logic       sample;
    logic [6:0] half;
    logic [7:0] nshift;
    logic       sclk;
    logic       link_rst;
    logic       link_miso;
    logic       link_tgl;
    logic       link_mid;
    logic [7:0] link_hold;
    logic [3:0] sync_q;
    logic       miso_s;
    logic       ss_n_s;
    logic       tgl_s;
    logic       mid_s;

    // ------------------------------------------------------------------
    // Crossings into mclk
    // ------------------------------------------------------------------
    sms_sync #(
        .W (4)
    ) u_sync (
        .clk (mclk),
        .rst (rst),
        .d   ({pins_in.miso_i, pins_in.ss_n_i, link_tgl, link_mid}),
        .q   (sync_q)
    );

    assign miso_s = sync_q[3];
    assign ss_n_s = sync_q[2];
    assign tgl_s  = sync_q[1];
    assign mid_s  = sync_q[0];

    // ------------------------------------------------------------------
    // Slave link on its own clock
    // ------------------------------------------------------------------
    // Sample edge becomes the rising edge of sclk in all four modes
    assign sclk = sck_link ^ (s_q.ctrl.clock_idle_level
                            ^ s_q.ctrl.clock_sample_phase);
    // Link logic is held clear while deselected or not a slave
    assign link_rst = rst | pins_in.ss_n_i | ~slave_mode;

    sms_slave_link u_link (
        .sclk      (sclk),
        .arst      (link_rst),
        .mosi      (pins_in.mosi_i),
        .tx        (s_q.tx),
        .order_lsb (s_q.ctrl.bit_order_select),
        .miso      (link_miso),
        .tgl       (link_tgl),
        .hold      (link_hold),
        .mid       (link_mid)
    );

    // ------------------------------------------------------------------
    // Mode and rate decode
    // ------------------------------------------------------------------
    // Unit works only with the power gate open and enable set
    assign en          = s_q.ctrl.enable & ~serial_power_gate_bit;
    assign master_mode = en & s_q.ctrl.master_select_bit;
    assign slave_mode  = en & ~s_q.ctrl.master_select_bit;

    // SCK half period picked by rate and double rate
    always_comb
    begin
        case ({s_q.ctrl.double_rate_bit, s_q.ctrl.rate})
            3'h0:    half = sms_pkg::HALF_NORM_0;
            3'h1:    half = sms_pkg::HALF_NORM_1;
            3'h2:    half = sms_pkg::HALF_NORM_2;
            3'h3:    half = sms_pkg::HALF_NORM_3;
            3'h4:    half = sms_pkg::HALF_DBL_0;
            3'h5:    half = sms_pkg::HALF_DBL_1;
            3'h6:    half = sms_pkg::HALF_DBL_2;
            default: half = sms_pkg::HALF_DBL_3;
        endcase
    end

    // Transfer in progress: master running or slave mid byte
    assign busy = (s_q.mst == sms_pkg::M_RUN) | (slave_mode & mid_s);
    // Another master selecting us while SS is an input
    assign fault = master_mode & dir.ss_is_input & ~ss_n_s;
    // New slave byte, ignored once deselect has wiped the link
    assign done_evt = slave_mode & (tgl_s != s_q.seen) & ~ss_n_s;
    // Status read with a flag set, then a data access, clears flags
    assign clr  = s_q.armed & (sw.data_rd | sw.data_wr);
    assign tick = (s_q.div == half - 7'h01);
    // Even edges lead; phase picks sample on leading or trailing
    assign sample = (s_q.edges[0] == s_q.ctrl.clock_sample_phase);
    assign nshift = s_q.ctrl.bit_order_select
                  ? {miso_s, s_q.shift[7:1]}
                  : {s_q.shift[6:0], miso_s};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        s_d.seen = tgl_s;

        // Control write
        if (sw.ctrl_wr)
            s_d.ctrl = ctrl_in;

        // Flag clears come first so that a same-cycle set wins
        if (clr)
        begin
            s_d.done  = 1'b0;
            s_d.coll  = 1'b0;
            s_d.armed = 1'b0;
        end
        if (sw.irq_ack)
            s_d.done = 1'b0;
        if (sw.stat_rd && (s_q.done || s_q.coll))
            s_d.armed = 1'b1;

        // Data write: refused while shifting, else load and maybe start
        if (sw.data_wr && en)
        begin
            if (busy)
                s_d.coll = 1'b1;
            else
            begin
                s_d.tx = sw.wdata;
                if (master_mode)
                begin
                    s_d.mst   = sms_pkg::M_RUN;
                    s_d.shift = sw.wdata;
                    s_d.mosi  = s_q.ctrl.bit_order_select
                              ? sw.wdata[0] : sw.wdata[7];
                    s_d.div   = 7'h00;
                    s_d.edges = 4'h0;
                end
            end
        end

        // Master clock generator
        if (s_q.mst == sms_pkg::M_RUN)
        begin
            if (tick)
            begin
                s_d.div   = 7'h00;
                s_d.sck   = ~s_q.sck;
                s_d.edges = s_q.edges + 4'h1;
                if (sample)
                    s_d.shift = nshift;
                else
                    s_d.mosi = s_q.ctrl.bit_order_select
                             ? s_q.shift[0] : s_q.shift[7];
                if (s_q.edges == sms_pkg::EDGE_LAST)
                begin
                    s_d.mst    = sms_pkg::M_IDLE;
                    s_d.done   = 1'b1;
                    s_d.rx_buf = sample ? nshift : s_q.shift;
                end
            end
            else
                s_d.div = s_q.div + 7'h01;
        end
        else
            s_d.sck = s_q.ctrl.clock_idle_level;

        // Slave byte arrival
        if (done_evt)
        begin
            s_d.done   = 1'b1;
            s_d.rx_buf = link_hold;
        end

        // Mode fault: fall back to slave and flag it
        if (fault)
        begin
            s_d.ctrl.master_select_bit = 1'b0;
            s_d.done = 1'b1;
            s_d.mst  = sms_pkg::M_IDLE;
        end

        // Disabled or powered down: stop at once
        if (!en || !s_q.ctrl.master_select_bit)
        begin
            s_d.mst = sms_pkg::M_IDLE;
            if (!en)
                s_d.sck = s_q.ctrl.clock_idle_level;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_q        <= '0;
            s_q.ctrl   <= sms_pkg::CTRL_RST;
            s_q.tx     <= sms_pkg::DATA_RST;
            s_q.rx_buf <= sms_pkg::DATA_RST;
            s_q.mst    <= sms_pkg::M_IDLE;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign serial_control_reg = s_q.ctrl;
    assign serial_data_reg    = s_q.rx_buf;

    // Status seen by software
    always_comb
    begin
        serial_status_reg.transfer_done_flag   = s_q.done;
        serial_status_reg.write_collision_flag = s_q.coll;
        serial_status_reg.busy                 = busy;
    end

    // Interrupt and idle wake share this request
    assign irq_req = s_q.done & s_q.ctrl.transfer_irq_enable;

    // Pin drive with the direction override
    always_comb
    begin
        pins_out.sck_o   = s_q.sck;
        pins_out.sck_oe  = master_mode & dir.sck_out;
        pins_out.mosi_o  = s_q.mosi;
        pins_out.mosi_oe = master_mode & dir.mosi_out;
        pins_out.miso_o  = link_miso;
        pins_out.miso_oe = slave_mode & dir.miso_out
                         & ~ss_n_s;
    end

endmodule

// ### core/sms_sync.sv
// Two flip-flop level synchroniser, any width.
// Assumes each bit is a level that is stable for several clocks.
`timescale 1ns/100ps
module sms_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sms_sync_s;

    sms_sync_s s_q;
    sms_sync_s s_d;

    // First stage feeds only the second stage
    always_comb
    begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign q = s_q.s2;

endmodule

// ### dv/sms_far_slave.sv
// Behavioural far-end slave on the link while the unit is master.
// Assumes mode, order and tx are set before its select falls.
`timescale 1ns/100ps
module sms_far_slave (
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic [1:0] mode,
    input  wire logic       lsb,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic [7:0]      rx
);
    int unsigned n;
    logic        ss_l;

    // Bit k of the byte in the chosen order
    function automatic logic pick(input int unsigned k);
        pick = lsb ? tx[k[2:0]] : tx[3'h7 - k[2:0]];
    endfunction

    // One process owns the line: select loads the first bit when mode[0] is 0,
    // else select or release shows the inverse; one clock edge samples, the other sets up
    initial
    begin
        miso = 1'b0;
        ss_l = 1'b1;
        n    = 0;
        forever
        begin
            @(ss_n or sck);
            if (ss_n != ss_l)
            begin
                n    = 0;
                miso = (ss_n || mode[0]) ? ~miso : pick(0);
            end
            else if (!ss_n)
            begin
                if (sck == ~(mode[1] ^ mode[0]))
                begin
                    rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
                    n = n + 1;
                end
                else
                    miso = (n < 8) ? pick(n) : ~miso;
            end
            ss_l = ss_n;
        end
    end
endmodule

// ### dv/sms_spi_unit_asserts.sv
// Port checker for the serial shift unit, bound into its top module.
// Assumes one watched domain, mclk, with rst as its async reset.
`timescale 1ns/100ps
module sms_spi_unit_asserts (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  serial_power_gate_bit,
    input wire sms_pkg::sms_sw_req_s  sw,
    input wire sms_pkg::sms_dir_s     dir,
    input wire sms_pkg::sms_pin_in_s  pins_in,
    input wire sms_pkg::sms_ctrl_s    serial_control_reg,
    input wire sms_pkg::sms_status_s  serial_status_reg,
    input wire logic                  irq_req,
    input wire sms_pkg::sms_pin_out_s pins_out
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    localparam logic [6:0] HALF_TBL [8] = '{
        sms_pkg::HALF_NORM_0, sms_pkg::HALF_NORM_1, sms_pkg::HALF_NORM_2,
        sms_pkg::HALF_NORM_3, sms_pkg::HALF_DBL_0, sms_pkg::HALF_DBL_1,
        sms_pkg::HALF_DBL_2, sms_pkg::HALF_DBL_3};
    logic        on, mst, busy, done;
    logic [10:0] busy_cnt_q;
    logic [10:0] byte_len;

    // Short names for the watched state; a byte is sixteen half periods
    assign on = serial_control_reg.enable && !serial_power_gate_bit;
    assign mst = serial_control_reg.master_select_bit;
    assign busy = serial_status_reg.busy;
    assign done = serial_status_reg.transfer_done_flag;
    assign byte_len = {HALF_TBL[{serial_control_reg.double_rate_bit,
                                 serial_control_reg.rate}], 4'h0};

    // Counts clocks spent shifting the current byte
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            busy_cnt_q <= 11'h000;
        else
            busy_cnt_q <= busy ? busy_cnt_q + 11'h001 : 11'h000;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    irq_follow_a: assert property (
        irq_req == (done && serial_control_reg.transfer_irq_enable))
        else $error("irq_req does not follow flag and enable");
    start_write_a: assert property (
        on && mst && !busy && sw.data_wr |=> busy)
        else $error("master write did not start a byte");
    gate_off_a: assert property (
        serial_power_gate_bit && !busy && sw.data_wr |=> !busy)
        else $error("gated unit started a byte");
    collide_set_a: assert property (
        busy && sw.data_wr |=> serial_status_reg.write_collision_flag)
        else $error("write while busy left collision clear");
    byte_length_a: assert property (
        $fell(busy) && mst |-> busy_cnt_q == byte_len)
        else $error("master byte length is wrong");
    done_stops_a: assert property (
        $rose(done) && mst |-> $fell(busy))
        else $error("done flag without clock stop");
    master_pins_a: assert property (
        (on && mst) [*2] |-> !pins_out.miso_oe)
        else $error("master drives its data input");
    slave_pins_a: assert property (
        (on && !mst) [*2] |-> !pins_out.sck_oe && !pins_out.mosi_oe)
        else $error("slave drives clock or master output");
    deselect_idle_a: assert property (
        (on && !mst && pins_in.ss_n_i) [*3] |-> !pins_out.miso_oe)
        else $error("deselected slave drives its output");
    sck_idle_a: assert property (
        (on && mst && !busy && $stable(serial_control_reg)) [*3]
            |-> pins_out.sck_o == serial_control_reg.clock_idle_level)
        else $error("idle clock level is wrong");
    mode_fault_a: assert property (
        (on && mst && dir.ss_is_input && !pins_in.ss_n_i) [*3] |=> !mst)
        else $error("master kept mode with select low");
endmodule

// ### dv/tb_top.sv
// Self-checking bench: unit as master to a far slave model, then as
// slave to a bench master. Assumes the checker and model compile first.
`timescale 1ns/100ps
module tb_top;
    localparam logic [4:0] WR_CTRL = 5'h10;
    localparam logic [4:0] WR_DATA = 5'h08;
    localparam logic [4:0] RD_DATA = 5'h04;
    localparam logic [4:0] RD_STAT = 5'h02;
    localparam logic [4:0] ACK     = 5'h01;
    logic                  mclk = 1'b0, lclk = 1'b0, rst = 1'b1;
    logic                  gate = 1'b1, sck_m = 1'b0, tb_mosi = 1'b0;
    logic                  u_ss_n = 1'b1, p_ss_n = 1'b1, p_lsb = 1'b0;
    logic [1:0]            p_mode = 2'h0;
    logic [7:0]            p_tx = 8'h00, p_rx, rdata;
    logic                  p_miso, irq, sck_w, mosi_w, miso_w;
    sms_pkg::sms_ctrl_s    cfg = '0, ctrl = '0, ctrl_q;
    sms_pkg::sms_sw_req_s  sw = '0;
    sms_pkg::sms_dir_s     dir = 4'hC;
    sms_pkg::sms_pin_in_s  pins_in;
    sms_pkg::sms_status_s  stat;
    sms_pkg::sms_pin_out_s pins_out;
    int                    mismatches = 0, compares = 0;

    // System clock; link base clock with its own phase
    always #25 mclk = ~mclk;
    initial
    begin
        #7;
        forever #32 lclk = ~lclk;
    end

    // Pins resolved between unit, far model and bench master
    assign sck_w = pins_out.sck_oe ? pins_out.sck_o : sck_m;
    assign mosi_w = pins_out.mosi_oe ? pins_out.mosi_o : tb_mosi;
    assign miso_w = pins_out.miso_oe ? pins_out.miso_o : p_miso;
    assign pins_in = {mosi_w, miso_w, u_ss_n};

    sms_spi_unit i_sms_spi_unit (
        .mclk(mclk), .rst(rst), .sck_link(sck_w),
        .serial_power_gate_bit(gate), .ctrl_in(ctrl), .sw(sw), .dir(dir),
        .pins_in(pins_in), .serial_control_reg(ctrl_q),
        .serial_status_reg(stat), .serial_data_reg(rdata), .irq_req(irq),
        .pins_out(pins_out));
    sms_far_slave i_sms_far_slave (
        .sck(sck_w), .ss_n(p_ss_n), .mosi(mosi_w), .mode(p_mode),
        .lsb(p_lsb), .tx(p_tx), .miso(p_miso), .rx(p_rx));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic op(input logic [4:0] kind, input logic [7:0] d);
        @(posedge mclk);
        ctrl <= cfg;
        sw <= {kind, d};
        @(posedge mclk);
        sw <= '0;
    endtask

    task automatic wait_done();
        for (int k = 0; k < 1500; k++)
            if (stat.transfer_done_flag !== 1'b1)
                @(negedge mclk);
        check("done", stat.transfer_done_flag, 1'b1);
    endtask

    task automatic clear_flags();
        op(RD_STAT, 8'h00);
        op(RD_DATA, 8'h00);
        @(negedge mclk);
        check("flags", stat[2:1], 2'h0);
    endtask

    // Bench master: each clock phase lasts two link base periods
    task automatic slave_xfer(input logic [1:0] md, input logic lsb,
                              input logic [7:0] mo, so);
        logic [7:0] got;
        int         k;
        @(posedge lclk);
        u_ss_n <= 1'b0;
        for (int j = 0; j < 8; j++)
        begin
            k = lsb ? j : 7 - j;
            for (int h = 0; h < 2; h++)
            begin
                if (md[0] == h[0])
                    tb_mosi <= mo[k];
                repeat (2) @(posedge lclk);
                if (md[0] == h[0])
                    got[k] = miso_w;
                sck_m <= ~sck_m;
            end
        end
        repeat (2) @(posedge lclk);
        tb_mosi <= ~tb_mosi;
        check("slave tx", got, so);
        wait_done();
        @(posedge mclk);
        u_ss_n <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] mo, so;
        logic [1:0] rt;
        void'($urandom(54537));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check("rst ctrl", ctrl_q, sms_pkg::CTRL_RST);
        check("rst data", rdata, sms_pkg::DATA_RST);
        check("rst pins", {stat, irq, pins_out}, 10'h000);
        cfg = 9'h1A0;
        op(WR_CTRL, 8'h00);
        op(WR_DATA, 8'hA5);
        repeat (40) @(negedge mclk);
        check("gated", {stat, irq}, 4'h0);
        @(posedge mclk);
        gate <= 1'b0;
        // Master bytes over all modes, orders and both speeds
        for (int i = 0; i < 16; i++)
        begin
            // Fastest rate only twice: synced data in needs 2+ clocks
            rt = (i[2:0] == 3'h0) ? 2'h0 : 2'h1 + 2'($urandom % 3);
            mo = 8'($urandom);
            so = 8'($urandom);
            cfg = {2'b11, i[2], 1'b1, i[1:0], rt, i[3]};
            p_mode = i[1:0];
            p_lsb = i[2];
            p_tx = so;
            op(WR_CTRL, 8'h00);
            // Let the clock reach its new idle level before select
            repeat (2) @(negedge mclk);
            p_ss_n = 1'b0;
            op(WR_DATA, mo);
            op(WR_DATA, ~mo);
            wait_done();
            if (rt != 2'h0)
                check("master rx", rdata, so);
            check("far rx", p_rx, mo);
            check("irq", irq, 1'b1);
            check("collision", stat.write_collision_flag, 1'b1);
            if (i[0])
            begin
                op(ACK, 8'h00);
                @(negedge mclk);
                check("ack", stat[2:1], 2'h1);
            end
            clear_flags();
            p_ss_n = 1'b1;
        end
        // Select pulled low under a master with select as input
        cfg = 9'h1A0;
        op(WR_CTRL, 8'h00);
        dir <= 4'hD;
        u_ss_n <= 1'b0;
        repeat (8) @(negedge mclk);
        check("fault", {ctrl_q.master_select_bit, stat[2]}, 2'h1);
        @(posedge mclk);
        u_ss_n <= 1'b1;
        clear_flags();
        // Slave bytes in all four modes, data loaded while deselected
        dir <= 4'h3;
        for (int i = 0; i < 4; i++)
        begin
            mo = 8'($urandom);
            so = 8'($urandom);
            cfg = {2'b11, 1'($urandom), 1'b0, i[1:0], 3'h0};
            op(WR_CTRL, 8'h00);
            sck_m <= cfg.clock_idle_level;
            op(WR_DATA, so);
            slave_xfer(i[1:0], cfg.bit_order_select, mo, so);
            check("slave rx", rdata, mo);
            op(WR_DATA, 8'h3C);
            @(negedge mclk);
            check("reload", stat.write_collision_flag, 1'b0);
            clear_flags();
        end
        conclude();
    end

    // Cuts a hang short well past the longest expected run
    initial
    begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        conclude();
    end
endmodule

bind sms_spi_unit sms_spi_unit_asserts i_sms_spi_unit_asserts (
    .mclk(mclk), .rst(rst), .serial_power_gate_bit(serial_power_gate_bit),
    .sw(sw), .dir(dir), .pins_in(pins_in),
    .serial_control_reg(serial_control_reg),
    .serial_status_reg(serial_status_reg), .irq_req(irq_req),
    .pins_out(pins_out));

// ### shared/sms_pkg.sv
// Shared types and constants of the serial shift unit.
// Assumes one system clock domain plus the link clock at the SCK pin.
package sms_pkg;

    // ------------------------------------------------------------------
    // Reset values and byte framing
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [3:0] EDGE_LAST = 4'hF;

    // ------------------------------------------------------------------
    // SCK half periods in system clocks, indexed by the rate select
    // ------------------------------------------------------------------
    localparam logic [6:0] HALF_NORM_0 = 7'h02;
    localparam logic [6:0] HALF_NORM_1 = 7'h08;
    localparam logic [6:0] HALF_NORM_2 = 7'h20;
    localparam logic [6:0] HALF_NORM_3 = 7'h40;
    localparam logic [6:0] HALF_DBL_0  = 7'h01;
    localparam logic [6:0] HALF_DBL_1  = 7'h04;
    localparam logic [6:0] HALF_DBL_2  = 7'h10;
    localparam logic [6:0] HALF_DBL_3  = 7'h20;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       transfer_irq_enable;
        logic       enable;
        logic       bit_order_select;   // 1: LSB first
        logic       master_select_bit;
        logic       clock_idle_level;
        logic       clock_sample_phase;
        logic [1:0] rate;
        logic       double_rate_bit;
    } sms_ctrl_s;

    localparam sms_ctrl_s CTRL_RST = '0;

    typedef struct packed {
        logic       ctrl_wr;
        logic       data_wr;
        logic       data_rd;
        logic       stat_rd;
        logic       irq_ack;
        logic [7:0] wdata;
    } sms_sw_req_s;

    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic busy;
    } sms_status_s;

    typedef struct packed {
        logic sck_out;
        logic mosi_out;
        logic miso_out;
        logic ss_is_input;
    } sms_dir_s;

    typedef struct packed {
        logic mosi_i;
        logic miso_i;
        logic ss_n_i;
    } sms_pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } sms_pin_out_s;

    typedef enum logic {M_IDLE, M_RUN} sms_mstate_e;

endpackage
